// ===== verilog/cmo_core.sv
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - No interrupt at all unless the global enable is set.
// - A source reaches the interrupt only while its own enable is set.
// - Error source interrupts on bus-off entry or counter limit.
// - Status source interrupts on transfer completion or bus error.
// - Object transactions interrupt only with that object's enable.
// - Cause reads status code, else highest-priority pending object number.
// - Reading controller status clears a pending status interrupt.
// - Object pending clears by clear command or read-and-clear of the message.
// - Readable bitmap of objects with pending interrupts.
// - Thirty-two configurable objects numbered one to thirty-two.
// - Invalidated object stops sending, receiving and interrupting.
// - Fresh-data flag set on store, cleared on host read.
// - Overrun flag set when unread frame gets overwritten.
// - Five object types incl. remote receive with auto answer.
// - Identifier standard or extended length.
// - Filtering compares only mask-selected identifier bits.
// - Separate transmit and receive interrupt enables per object.
// - Up to eight data bytes plus data length code.
// - New configuration fully replaces the old one.
// - Warning flag when either counter reaches the warning limit.
// - Status holds three-bit last error code field.
// - Bitmaps of transmit requests, fresh data and valid objects.
module cmo_core (
	input wire logic ref_clk, // Module clock
	input wire logic srst, // Sync reset, active high
	input wire logic ce, // Clock enable
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped
	output logic irq, // Processor interrupt
	input wire logic rx_valid, // Engine frame received pulse
	input wire logic [28:0] rx_id, // Received identifier
	input wire logic rx_xtd, // Received extended id
	input wire logic rx_rtr, // Received remote frame
	input wire logic [3:0] rx_dlc, // Received length
	input wire logic [63:0] rx_data, // Received payload
	output logic tx_req, // Frame offered to engine
	output logic [4:0] tx_obj, // Offered object index
	output logic [28:0] tx_id, // Offered identifier
	output logic tx_xtd, // Offered extended id
	output logic tx_rtr, // Offered remote frame
	output logic [3:0] tx_dlc, // Offered length
	output logic [63:0] tx_data, // Offered payload
	input wire logic tx_done, // Engine sent offered frame
	input wire logic lec_valid, // Last error code update pulse
	input wire logic [2:0] lec_in, // Last error code
	input wire logic bus_off, // Bus-off level
	input wire logic err_passive, // Error passive level
	input wire logic [7:0] tec, // Transmit error counter
	input wire logic [7:0] rec // Receive error counter
);
	import cmo_pkg::*;

	typedef struct packed {
		cmo_obj_t [NOBJ-1:0] obj;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
		logic mie;
		logic eie;
		logic sie;
		logic stat_pend;
		logic err_pend;
		logic [2:0] lec;
		logic txok;
		logic rxok;
		logic boff_q;
		logic ewarn_q;
		logic [31:0] stg_id;
		logic [31:0] stg_mask;
		logic [31:0] stg_cfg;
		logic [31:0] stg_dlo;
		logic [31:0] stg_dhi;
		cmo_tx_st_t tx_st;
		logic [4:0] tx_obj;
		logic [28:0] tx_id;
		logic tx_xtd;
		logic tx_rtr;
		logic [3:0] tx_dlc;
		logic [63:0] tx_data;
	} cmo_state_t;

	cmo_state_t st_ff;
	cmo_state_t nxt_st;
	logic [31:0] hit_vec, txq_vec, pend_vec, fresh_vec, valid_vec, txmap_vec;
	logic [5:0] hit_first, txq_first, pend_first;
	logic [31:0] cause_w;
	logic ewarn_w, access_w, wr_w, cmd_ok_w, stat_set_w, err_set_w;
	logic [4:0] cmd_idx_w;
	cmo_op_t cmd_op_w;

	// Lowest set bit: {found, index}
	function automatic logic [5:0] first_set(input logic [31:0] v);
		logic [5:0] r;
		r = 6'h00;
		for (int i = NOBJ - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 5'(i)};
			end
		end
		return r;
	endfunction : first_set

	// ************************************
	// Per-object match and bitmaps
	// ************************************
	for (genvar g = 0; g < NOBJ; g++) begin : g_obj
		logic [28:0] cmp_w;
		logic type_ok_w;
		assign cmp_w = st_ff.obj[g].filt ? st_ff.obj[g].mask : ID_ALL;
		assign type_ok_w = rx_rtr ? (st_ff.obj[g].typ == TYPE_RXR || st_ff.obj[g].typ == TYPE_AUTO)
			: (st_ff.obj[g].typ == TYPE_RX || st_ff.obj[g].typ == TYPE_TXR);
		assign hit_vec[g] = st_ff.obj[g].valid && type_ok_w && st_ff.obj[g].xtd == rx_xtd
			&& ((st_ff.obj[g].id ^ rx_id) & cmp_w) == 29'h0;
		assign txq_vec[g] = st_ff.obj[g].valid && st_ff.obj[g].txreq;
		assign pend_vec[g] = st_ff.obj[g].pend;
		assign fresh_vec[g] = st_ff.obj[g].fresh;
		assign valid_vec[g] = st_ff.obj[g].valid;
		assign txmap_vec[g] = st_ff.obj[g].txreq;
	end

	// Decode, priority and cause
	assign hit_first = first_set(hit_vec);
	assign txq_first = first_set(txq_vec);
	assign pend_first = first_set(pend_vec);
	assign ewarn_w = tec >= EWARN_LIMIT || rec >= EWARN_LIMIT;
	assign access_w = psel && penable && st_ff.pready;
	assign wr_w = access_w && pwrite;
	assign cmd_ok_w = pwdata[5:0] != 6'h00 && pwdata[5:0] <= 6'h20;
	assign cmd_idx_w = 5'(pwdata[5:0] - 6'h01);
	assign cmd_op_w = cmo_op_t'(pwdata[CMD_OP+:3]);
	assign stat_set_w = tx_done && st_ff.tx_st == TX_BUSY || rx_valid || lec_valid && lec_in != LEC_NONE;
	assign err_set_w = bus_off && !st_ff.boff_q || ewarn_w && !st_ff.ewarn_q;
	always_comb begin
		if ((st_ff.stat_pend && st_ff.sie) || (st_ff.err_pend && st_ff.eie)) begin
			cause_w = STATUS_CODE;
		end else if (pend_first[5]) begin
			cause_w = {27'h0, pend_first[4:0]} + 32'h1;
		end else begin
			cause_w = RST_WORD;
		end
	end

	// ************************************
	// Next state
	// ************************************
	always_comb begin
		nxt_st = st_ff;
		// APB: data latched in setup, ready in access
		nxt_st.pready = psel && !penable;
		nxt_st.pslverr = 1'b0;
		nxt_st.prdata = RST_WORD;
		if (psel && !penable) begin
			case (paddr)
				OFF_CTRL: nxt_st.prdata = {29'h0, st_ff.sie, st_ff.eie, st_ff.mie};
				OFF_STATUS: nxt_st.prdata = {24'h0, st_ff.boff_q, st_ff.ewarn_q, err_passive,
					st_ff.rxok, st_ff.txok, st_ff.lec};
				OFF_CAUSE: nxt_st.prdata = cause_w;
				OFF_PEND: nxt_st.prdata = pend_vec;
				OFF_TXREQ: nxt_st.prdata = txmap_vec;
				OFF_FRESH: nxt_st.prdata = fresh_vec;
				OFF_VALID: nxt_st.prdata = valid_vec;
				OFF_CMD: nxt_st.prdata = RST_WORD;
				OFF_ID: nxt_st.prdata = st_ff.stg_id;
				OFF_MASK: nxt_st.prdata = st_ff.stg_mask;
				OFF_CFG: nxt_st.prdata = st_ff.stg_cfg;
				OFF_DLO: nxt_st.prdata = st_ff.stg_dlo;
				OFF_DHI: nxt_st.prdata = st_ff.stg_dhi;
				default: nxt_st.pslverr = 1'b1;
			endcase
		end
		// Status read clears status interrupt
		if (access_w && !pwrite && paddr == OFF_STATUS) begin
			nxt_st.stat_pend = 1'b0;
			nxt_st.err_pend = 1'b0;
			nxt_st.txok = 1'b0;
			nxt_st.rxok = 1'b0;
		end
		// Register writes and object commands
		if (wr_w) begin
			case (paddr)
				OFF_CTRL: begin
					nxt_st.mie = pwdata[CTRL_MIE];
					nxt_st.eie = pwdata[CTRL_EIE];
					nxt_st.sie = pwdata[CTRL_SIE];
				end
				OFF_ID: nxt_st.stg_id = pwdata;
				OFF_MASK: nxt_st.stg_mask = pwdata;
				OFF_CFG: nxt_st.stg_cfg = pwdata;
				OFF_DLO: nxt_st.stg_dlo = pwdata;
				OFF_DHI: nxt_st.stg_dhi = pwdata;
				OFF_CMD: begin
					if (cmd_op_w == OP_CLR_STAT) begin
						nxt_st.stat_pend = 1'b0;
						nxt_st.err_pend = 1'b0;
					end else if (cmd_ok_w) begin
						case (cmd_op_w)
							OP_WRITE: begin
								// Whole object replaced
								nxt_st.obj[cmd_idx_w] = '0;
								nxt_st.obj[cmd_idx_w].valid = 1'b1;
								nxt_st.obj[cmd_idx_w].typ = cmo_type_t'(st_ff.stg_cfg[2:0]);
								nxt_st.obj[cmd_idx_w].xtd = st_ff.stg_id[ID_XTD];
								nxt_st.obj[cmd_idx_w].id = st_ff.stg_id[28:0];
								nxt_st.obj[cmd_idx_w].mask = st_ff.stg_mask[28:0];
								nxt_st.obj[cmd_idx_w].filt = st_ff.stg_cfg[CFG_FILT];
								nxt_st.obj[cmd_idx_w].txie = st_ff.stg_cfg[CFG_TXIE];
								nxt_st.obj[cmd_idx_w].rxie = st_ff.stg_cfg[CFG_RXIE];
								nxt_st.obj[cmd_idx_w].dlc = st_ff.stg_cfg[CFG_DLC+:4] > DLC_MAX ? DLC_MAX
									: st_ff.stg_cfg[CFG_DLC+:4];
								nxt_st.obj[cmd_idx_w].data = {st_ff.stg_dhi, st_ff.stg_dlo};
								nxt_st.obj[cmd_idx_w].txreq = st_ff.stg_cfg[2:0] == TYPE_TX
									|| st_ff.stg_cfg[2:0] == TYPE_TXR;
							end
							OP_READ, OP_READ_CLR: begin
								nxt_st.stg_id = {2'h0, st_ff.obj[cmd_idx_w].xtd, st_ff.obj[cmd_idx_w].id};
								nxt_st.stg_mask = {3'h0, st_ff.obj[cmd_idx_w].mask};
								nxt_st.stg_cfg = {19'h0, st_ff.obj[cmd_idx_w].valid, st_ff.obj[cmd_idx_w].ovr,
									st_ff.obj[cmd_idx_w].fresh, st_ff.obj[cmd_idx_w].dlc, st_ff.obj[cmd_idx_w].rxie,
									st_ff.obj[cmd_idx_w].txie, st_ff.obj[cmd_idx_w].filt, st_ff.obj[cmd_idx_w].typ};
								nxt_st.stg_dlo = st_ff.obj[cmd_idx_w].data[31:0];
								nxt_st.stg_dhi = st_ff.obj[cmd_idx_w].data[63:32];
								nxt_st.obj[cmd_idx_w].fresh = 1'b0;
								nxt_st.obj[cmd_idx_w].ovr = 1'b0;
								if (cmd_op_w == OP_READ_CLR) begin
									nxt_st.obj[cmd_idx_w].pend = 1'b0;
								end
							end
							OP_CLR_PEND: nxt_st.obj[cmd_idx_w].pend = 1'b0;
							OP_INVAL: begin
								// Freed object drops valid, transmit request, pending and fresh flags
								nxt_st.obj[cmd_idx_w].valid = 1'b0;
								nxt_st.obj[cmd_idx_w].txreq = 1'b0;
								nxt_st.obj[cmd_idx_w].pend = 1'b0;
								nxt_st.obj[cmd_idx_w].fresh = 1'b0;
								if (st_ff.tx_st == TX_BUSY && st_ff.tx_obj == cmd_idx_w) begin
									nxt_st.tx_st = TX_IDLE;
								end
							end
							OP_TX: nxt_st.obj[cmd_idx_w].txreq = st_ff.obj[cmd_idx_w].valid;
							default: ;
						endcase
					end
				end
				default: ;
			endcase
		end
		// Engine status events, set wins over clear
		nxt_st.boff_q = bus_off;
		nxt_st.ewarn_q = ewarn_w;
		if (lec_valid) begin
			nxt_st.lec = lec_in;
		end
		if (stat_set_w) begin
			nxt_st.stat_pend = 1'b1;
		end
		if (err_set_w) begin
			nxt_st.err_pend = 1'b1;
		end
		if (rx_valid) begin
			nxt_st.rxok = 1'b1;
		end
		// Store received frame in first matching object
		if (rx_valid && hit_first[5]) begin
			if (!rx_rtr) begin
				nxt_st.obj[hit_first[4:0]].data = rx_data;
				nxt_st.obj[hit_first[4:0]].dlc = rx_dlc > DLC_MAX ? DLC_MAX : rx_dlc;
			end
			nxt_st.obj[hit_first[4:0]].ovr = st_ff.obj[hit_first[4:0]].fresh
				|| nxt_st.obj[hit_first[4:0]].ovr;
			nxt_st.obj[hit_first[4:0]].fresh = 1'b1;
			if (st_ff.obj[hit_first[4:0]].rxie) begin
				nxt_st.obj[hit_first[4:0]].pend = 1'b1;
			end
			if (st_ff.obj[hit_first[4:0]].typ == TYPE_AUTO) begin
				nxt_st.obj[hit_first[4:0]].txreq = 1'b1;
			end
		end
		// Transmit scheduler
		case (st_ff.tx_st)
			TX_IDLE: begin
				if (txq_first[5]) begin
					nxt_st.tx_st = TX_BUSY;
					nxt_st.tx_obj = txq_first[4:0];
					nxt_st.tx_id = st_ff.obj[txq_first[4:0]].id;
					nxt_st.tx_xtd = st_ff.obj[txq_first[4:0]].xtd;
					nxt_st.tx_rtr = st_ff.obj[txq_first[4:0]].typ == TYPE_TXR;
					nxt_st.tx_dlc = st_ff.obj[txq_first[4:0]].dlc;
					nxt_st.tx_data = st_ff.obj[txq_first[4:0]].data;
				end
			end
			TX_BUSY: begin
				if (tx_done) begin
					nxt_st.tx_st = TX_IDLE;
					nxt_st.txok = 1'b1;
					// A host request for the same object in this cycle survives completion
					if (!(wr_w && paddr == OFF_CMD && cmd_ok_w && cmd_idx_w == st_ff.tx_obj
						&& (cmd_op_w == OP_TX || cmd_op_w == OP_WRITE))) begin
						nxt_st.obj[st_ff.tx_obj].txreq = 1'b0;
					end
					if (st_ff.obj[st_ff.tx_obj].txie && nxt_st.obj[st_ff.tx_obj].valid) begin
						nxt_st.obj[st_ff.tx_obj].pend = 1'b1;
					end
				end
			end
			default: nxt_st.tx_st = TX_IDLE;
		endcase
		// Interrupt line gated by master and source enables
		nxt_st.irq = st_ff.mie && ((st_ff.sie && st_ff.stat_pend) || (st_ff.eie && st_ff.err_pend)
			|| pend_vec != 32'h0);
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			nxt_st_rst_apply: st_ff <= '0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from state
	assign prdata = st_ff.prdata;
	assign pready = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign irq = st_ff.irq;
	assign tx_req = st_ff.tx_st[0];
	assign tx_obj = st_ff.tx_obj;
	assign tx_id = st_ff.tx_id;
	assign tx_xtd = st_ff.tx_xtd;
	assign tx_rtr = st_ff.tx_rtr;
	assign tx_dlc = st_ff.tx_dlc;
	assign tx_data = st_ff.tx_data;

	// ************************************
	// Assertions
	// ************************************
	master_gate_a: assert property (@(posedge ref_clk) disable iff (srst)
		(ce && !st_ff.mie) |=> !irq) else $error("irq without master enable");
	source_gate_a: assert property (@(posedge ref_clk) disable iff (srst)
		(ce && !st_ff.sie && !st_ff.eie && pend_vec == 32'h0) |=> !irq) else $error("irq from disabled source");
	error_event_a: assert property (@(posedge ref_clk) disable iff (srst)
		(ce && bus_off && !st_ff.boff_q) |=> st_ff.err_pend) else $error("bus-off not flagged");
	status_event_a: assert property (@(posedge ref_clk) disable iff (srst)
		(ce && tx_done && tx_req) |=> st_ff.stat_pend && !tx_req) else $error("tx done not flagged");
	cause_code_a: assert property (@(posedge ref_clk) disable iff (srst)
		(!st_ff.stat_pend && !st_ff.err_pend && pend_vec == 32'h0) |-> cause_w == 32'h0) else $error("cause not zero");
	cause_obj_a: assert property (@(posedge ref_clk) disable iff (srst)
		(!st_ff.stat_pend && !st_ff.err_pend && pend_vec != 32'h0) |-> cause_w >= 32'h1 && cause_w <= 32'h20
		&& (pend_vec & (32'h1 << (cause_w[5:0] - 6'h1))) != 32'h0
		&& (pend_vec & ((32'h1 << (cause_w[5:0] - 6'h1)) - 32'h1)) == 32'h0) else $error("cause priority wrong");
	status_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
		(ce && access_w && !pwrite && paddr == OFF_STATUS && !stat_set_w && !err_set_w) |=> !st_ff.stat_pend)
		else $error("status read kept interrupt");
	inval_stop_a: assert property (@(posedge ref_clk) disable iff (srst)
		(ce && wr_w && paddr == OFF_CMD && cmd_ok_w && cmd_op_w == OP_INVAL) |=>
		(valid_vec & (32'h1 << $past(cmd_idx_w))) == 32'h0) else $error("object still valid");
	fresh_set_a: assert property (@(posedge ref_clk) disable iff (srst)
		(ce && rx_valid && hit_first[5]) |=> (fresh_vec & (32'h1 << $past(hit_first[4:0]))) != 32'h0)
		else $error("fresh flag not set");
	pend_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
		(ce && wr_w && paddr == OFF_CMD && cmd_ok_w && cmd_op_w == OP_CLR_PEND && !rx_valid && !tx_done) |=>
		(pend_vec & (32'h1 << $past(cmd_idx_w))) == 32'h0) else $error("pending not cleared");
	overrun_set_a: assert property (@(posedge ref_clk) disable iff (srst)
		(ce && rx_valid && hit_first[5] && fresh_vec[hit_first[4:0]]) |=> st_ff.obj[$past(hit_first[4:0])].ovr)
		else $error("overrun not flagged");
	apb_ready_a: assert property (@(posedge ref_clk) disable iff (srst)
		(ce && psel && !penable) |=> pready ##1 !pready) else $error("pready timing");
endmodule : cmo_core

// ===== verilog/cmo_pkg.sv
package cmo_pkg;
	// ************************************
	// Register map (byte addresses)
	// ************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_CAUSE = 8'h08;
	localparam logic [7:0] OFF_PEND = 8'h0C;
	localparam logic [7:0] OFF_TXREQ = 8'h10;
	localparam logic [7:0] OFF_FRESH = 8'h14;
	localparam logic [7:0] OFF_VALID = 8'h18;
	localparam logic [7:0] OFF_CMD = 8'h1C;
	localparam logic [7:0] OFF_ID = 8'h20;
	localparam logic [7:0] OFF_MASK = 8'h24;
	localparam logic [7:0] OFF_CFG = 8'h28;
	localparam logic [7:0] OFF_DLO = 8'h2C;
	localparam logic [7:0] OFF_DHI = 8'h30;
	// ************************************
	// Field positions
	// ************************************
	localparam int CTRL_MIE = 0;
	localparam int CTRL_EIE = 1;
	localparam int CTRL_SIE = 2;
	localparam int ST_TXOK = 3;
	localparam int ST_RXOK = 4;
	localparam int ST_EPASS = 5;
	localparam int ST_EWARN = 6;
	localparam int ST_BOFF = 7;
	localparam int ID_XTD = 29;
	localparam int CFG_FILT = 3;
	localparam int CFG_TXIE = 4;
	localparam int CFG_RXIE = 5;
	localparam int CFG_DLC = 6;
	localparam int CFG_FRESH = 10;
	localparam int CFG_OVR = 11;
	localparam int CFG_VALID = 12;
	localparam int CMD_OP = 8;
	// ************************************
	// Values and limits
	// ************************************
	localparam int NOBJ = 32;
	localparam logic [7:0] EWARN_LIMIT = 8'h60;
	localparam logic [3:0] DLC_MAX = 4'h8;
	localparam logic [31:0] STATUS_CODE = 32'h0000_8000;
	localparam logic [28:0] ID_ALL = 29'h1FFF_FFFF;
	localparam logic [2:0] LEC_NONE = 3'h0;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	typedef enum logic [2:0] {
		TYPE_TX = 3'b000,
		TYPE_TXR = 3'b001,
		TYPE_RX = 3'b010,
		TYPE_RXR = 3'b011,
		TYPE_AUTO = 3'b100
	} cmo_type_t;

	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_WRITE = 3'b001,
		OP_READ = 3'b010,
		OP_READ_CLR = 3'b011,
		OP_CLR_PEND = 3'b100,
		OP_INVAL = 3'b101,
		OP_CLR_STAT = 3'b110,
		OP_TX = 3'b111
	} cmo_op_t;

	typedef enum logic [0:0] {
		TX_IDLE = 1'b0,
		TX_BUSY = 1'b1
	} cmo_tx_st_t;

	typedef struct packed {
		logic valid;
		cmo_type_t typ;
		logic xtd;
		logic [28:0] id;
		logic [28:0] mask;
		logic filt;
		logic txie;
		logic rxie;
		logic [3:0] dlc;
		logic [63:0] data;
		logic fresh;
		logic ovr;
		logic txreq;
		logic pend;
	} cmo_obj_t;
endpackage : cmo_pkg

// ===== dv/cmo_engine_model.sv
`timescale 1ns/1ps
// ************************************
// Protocol engine stand-in
// ************************************
module cmo_engine_model (
	input wire logic ref_clk, // Module clock
	input wire logic tx_req, // Frame offered by block
	output logic tx_done, // Frame sent pulse
	output logic rx_valid, // Frame received pulse
	output logic [28:0] rx_id, // Received identifier
	output logic rx_xtd, // Received extended id
	output logic rx_rtr, // Received remote frame
	output logic [3:0] rx_dlc, // Received length
	output logic [63:0] rx_data // Received payload
);
	int dly = 3; // Cycles from offer to sent, less one
	int cnt = 0;

	// Idle levels at time zero
	initial begin
		tx_done = 1'b0;
		rx_valid = 1'b0;
		rx_id = 29'h0;
		rx_xtd = 1'b0;
		rx_rtr = 1'b0;
		rx_dlc = 4'h0;
		rx_data = 64'h0;
	end

	// Answer an offer dly+1 cycles after it rises, one pulse per offer
	always @(posedge ref_clk) begin
		tx_done <= 1'b0;
		if (tx_req === 1'b1 && tx_done === 1'b0) begin
			if (cnt >= dly) begin
				tx_done <= 1'b1;
				cnt <= 0;
			end else begin
				cnt <= cnt + 1;
			end
		end else begin
			cnt <= 0;
		end
	end

	// One data frame; fields scrambled afterwards so stale values never match
	task automatic send(input logic [28:0] id, input logic [63:0] d);
		@(posedge ref_clk);
		rx_valid <= 1'b1;
		rx_id <= id;
		rx_dlc <= 4'h8;
		rx_data <= d;
		@(posedge ref_clk);
		rx_valid <= 1'b0;
		rx_id <= ~id;
		rx_dlc <= 4'h7;
		rx_data <= ~d;
	endtask : send
endmodule : cmo_engine_model

// ===== dv/test_can_msg_object_irq.sv
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 64'(e), 64'(g))
module test_can_msg_object_irq;
	import cmo_pkg::*;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, sl, irq, rx_valid, rx_xtd, rx_rtr, tx_req, tx_xtd, tx_rtr, tx_done;
	logic [28:0] rx_id, tx_id;
	logic [3:0] rx_dlc, tx_dlc;
	logic [63:0] rx_data, tx_data;
	logic [4:0] tx_obj;
	logic lec_valid = 1'b0;
	logic [2:0] lec_in = 3'h0;
	logic bus_off = 1'b0;
	logic [7:0] tec = 8'h00;
	logic [7:0] rec = 8'h00;
	int error_cnt = 0;
	int total_checks = 0;

	always #2.5 ref_clk = ~ref_clk;

	cmo_core dut (.ref_clk(ref_clk), .srst(srst), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .rx_valid(rx_valid), .rx_id(rx_id), .rx_xtd(rx_xtd),
		.rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_data(rx_data), .tx_req(tx_req), .tx_obj(tx_obj),
		.tx_id(tx_id), .tx_xtd(tx_xtd), .tx_rtr(tx_rtr), .tx_dlc(tx_dlc), .tx_data(tx_data),
		.tx_done(tx_done), .lec_valid(lec_valid), .lec_in(lec_in), .bus_off(bus_off),
		.err_passive(1'b0), .tec(tec), .rec(rec));

	cmo_engine_model u_eng (.ref_clk(ref_clk), .tx_req(tx_req), .tx_done(tx_done),
		.rx_valid(rx_valid), .rx_id(rx_id), .rx_xtd(rx_xtd), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc),
		.rx_data(rx_data));

	// ************************************
	// Shared tasks
	// ************************************
	task summarize;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : summarize

	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %0h seen %0h", n, e, g);
		end
	endtask : chk

	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			`CHK("pready", 1, 0);
			summarize();
		end
		rd = prdata;
		sl = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(n, e, rd);
	endtask : rdchk

	task automatic cmd(input logic [5:0] n, input logic [2:0] op);
		apb(1'b1, OFF_CMD, {21'h0, op, 2'b00, n});
	endtask : cmd

	task automatic setobj(input logic [5:0] n, input logic [28:0] id, input logic [28:0] m,
		input logic [31:0] cfg, input logic [31:0] d);
		apb(1'b1, OFF_ID, {3'h0, id});
		apb(1'b1, OFF_MASK, {3'h0, m});
		apb(1'b1, OFF_CFG, cfg);
		apb(1'b1, OFF_DLO, d);
		cmd(n, OP_WRITE);
	endtask : setobj

	// Bounded wait for the offer line to reach v
	task automatic wait_tx(input logic v);
		int i;
		for (i = 0; i < 200 && tx_req !== v; i++) @(posedge ref_clk);
		if (i == 200) begin
			`CHK("tx_req", v, tx_req);
			summarize();
		end
	endtask : wait_tx

	// ************************************
	// Scenarios
	// ************************************
	task automatic s_reset;
		rdchk("cause", OFF_CAUSE, 32'h0);
		rdchk("pend", OFF_PEND, 32'h0);
		rdchk("valid", OFF_VALID, 32'h0);
		rdchk("unmapped", 8'h40, 32'h0);
		`CHK("slverr", 1, sl);
	endtask : s_reset

	// Filtered reception, overrun, priority, clear paths
	task automatic s_rx;
		setobj(6'd3, 29'h123, 29'h7F0, 32'h22A, 32'h0);
		setobj(6'd5, 29'h055, 29'h0, 32'h222, 32'h0);
		u_eng.send(29'h223, 64'h1);
		repeat (3) @(posedge ref_clk);
		rdchk("fresh", OFF_FRESH, 32'h0);
		u_eng.send(29'h12F, 64'h0102030405060708);
		u_eng.send(29'h12F, 64'h1122334455667788);
		u_eng.send(29'h055, 64'h9);
		repeat (3) @(posedge ref_clk);
		`CHK("irq off", 0, irq);
		rdchk("fresh", OFF_FRESH, 32'h14);
		rdchk("pend", OFF_PEND, 32'h14);
		apb(1'b0, OFF_STATUS, 32'h0);
		rdchk("cause", OFF_CAUSE, 32'h3);
		apb(1'b1, OFF_CTRL, 32'h1);
		repeat (3) @(posedge ref_clk);
		`CHK("irq obj", 1, irq);
		cmd(6'd3, OP_READ_CLR);
		apb(1'b0, OFF_CFG, 32'h0);
		`CHK("ovr", 1, rd[CFG_OVR]);
		rdchk("dlo", OFF_DLO, 32'h55667788);
		rdchk("dhi", OFF_DHI, 32'h11223344);
		rdchk("fresh", OFF_FRESH, 32'h10);
		rdchk("cause", OFF_CAUSE, 32'h5);
		cmd(6'd5, OP_CLR_PEND);
		rdchk("pend", OFF_PEND, 32'h0);
		repeat (3) @(posedge ref_clk);
		`CHK("irq clr", 0, irq);
	endtask : s_rx

	// Transmission, status gating and per-object transmit enable
	task automatic s_tx;
		u_eng.dly = 20;
		setobj(6'd2, 29'h3A5, 29'h0, 32'h100, 32'hDDCCBBAA);
		rdchk("txreq", OFF_TXREQ, 32'h2);
		wait_tx(1'b1);
		`CHK("tx_obj", 1, tx_obj);
		`CHK("tx_id", 29'h3A5, tx_id);
		`CHK("tx_xtd", 0, tx_xtd);
		`CHK("tx_rtr", 0, tx_rtr);
		`CHK("tx_dlc", 4, tx_dlc);
		`CHK("tx_dlo", 32'hDDCCBBAA, tx_data[31:0]);
		wait_tx(1'b0);
		repeat (3) @(posedge ref_clk);
		`CHK("irq sie", 0, irq);
		rdchk("pend", OFF_PEND, 32'h0);
		apb(1'b1, OFF_CTRL, 32'h5);
		repeat (3) @(posedge ref_clk);
		`CHK("irq stat", 1, irq);
		rdchk("cause", OFF_CAUSE, STATUS_CODE);
		apb(1'b0, OFF_STATUS, 32'h0);
		`CHK("txok", 1, rd[ST_TXOK]);
		repeat (3) @(posedge ref_clk);
		`CHK("irq read", 0, irq);
		rdchk("cause", OFF_CAUSE, 32'h0);
		u_eng.dly = 2;
		setobj(6'd2, 29'h3A5, 29'h0, 32'h110, 32'h0);
		wait_tx(1'b1);
		wait_tx(1'b0);
		apb(1'b0, OFF_STATUS, 32'h0);
		rdchk("pend", OFF_PEND, 32'h2);
		cmd(6'd2, OP_CLR_PEND);
	endtask : s_tx

	// Every type, replacement, edges of numbering, invalidation
	task automatic s_types;
		int t;
		apb(1'b1, OFF_CTRL, 32'h0);
		for (t = 0; t < 5; t++) begin
			setobj(6'(10 + t), 29'h40, 29'h0, 32'(t) | 32'h200, 32'h0);
			cmd(6'(10 + t), OP_READ);
			apb(1'b0, OFF_CFG, 32'h0);
			`CHK("type", t, rd[2:0]);
			`CHK("cfg valid", 1, rd[CFG_VALID]);
		end
		setobj(6'd10, 29'h7, 29'h0, 32'h222, 32'h0);
		cmd(6'd10, OP_READ);
		rdchk("id", OFF_ID, 32'h7);
		apb(1'b0, OFF_CFG, 32'h0);
		`CHK("type", 2, rd[2:0]);
		setobj(6'd32, 29'h3FF, 29'h0, 32'h222, 32'h0);
		cmd(6'd33, OP_WRITE);
		rdchk("valid", OFF_VALID, 32'h80003E16);
		cmd(6'd3, OP_INVAL);
		rdchk("valid", OFF_VALID, 32'h80003E12);
		u_eng.send(29'h123, 64'h5);
		repeat (3) @(posedge ref_clk);
		rdchk("pend", OFF_PEND, 32'h0);
		wait_tx(1'b0);
		apb(1'b0, OFF_STATUS, 32'h0);
	endtask : s_types

	// Error source, warning limit, last error codes, bus-off
	task automatic s_err;
		int l;
		apb(1'b1, OFF_CTRL, 32'h6);
		tec <= 8'd95;
		@(posedge ref_clk);
		apb(1'b0, OFF_STATUS, 32'h0);
		`CHK("ewarn", 0, rd[ST_EWARN]);
		tec <= 8'd96;
		repeat (3) @(posedge ref_clk);
		`CHK("irq master", 0, irq);
		apb(1'b1, OFF_CTRL, 32'h7);
		repeat (3) @(posedge ref_clk);
		`CHK("irq err", 1, irq);
		rdchk("cause", OFF_CAUSE, STATUS_CODE);
		apb(1'b0, OFF_STATUS, 32'h0);
		`CHK("ewarn", 1, rd[ST_EWARN]);
		for (l = 0; l < 7; l++) begin
			lec_valid <= 1'b1;
			lec_in <= 3'(l);
			@(posedge ref_clk);
			lec_valid <= 1'b0;
			apb(1'b0, OFF_STATUS, 32'h0);
			`CHK("lec", l, rd[2:0]);
		end
		repeat (3) @(posedge ref_clk);
		`CHK("irq read", 0, irq);
		apb(1'b1, OFF_CTRL, 32'h3);
		bus_off <= 1'b1;
		repeat (3) @(posedge ref_clk);
		`CHK("irq boff", 1, irq);
		apb(1'b0, OFF_STATUS, 32'h0);
		`CHK("busoff", 1, rd[ST_BOFF]);
		// Receive counter alone also reaches the warning limit
		tec <= 8'd0;
		@(posedge ref_clk);
		apb(1'b0, OFF_STATUS, 32'h0);
		`CHK("ewarn low", 0, rd[ST_EWARN]);
		rec <= 8'd96;
		@(posedge ref_clk);
		apb(1'b0, OFF_STATUS, 32'h0);
		`CHK("ewarn rec", 1, rd[ST_EWARN]);
	endtask : s_err

	// Main sequence
	initial begin
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		s_reset();
		s_rx();
		s_tx();
		s_types();
		s_err();
		summarize();
	end
endmodule : test_can_msg_object_irq
